// ===== rtl/dee_if.sv
`timescale 1ns/1ps
interface dee_if (
  input logic pclk,
  input logic presetn,
  input logic por_n
);
  logic sfr_we;
  logic sfr_re;
  logic [2:0] sfr_sel;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;

  modport dev (
    input pclk,
    input presetn,
    input por_n,
    input sfr_we,
    input sfr_re,
    input sfr_sel,
    input sfr_wdata,
    output sfr_rdata
  );

  modport host (
    input pclk,
    input presetn,
    input por_n,
    output sfr_we,
    output sfr_re,
    output sfr_sel,
    output sfr_wdata,
    input sfr_rdata
  );
endinterface

// ===== rtl/dee_nv_device.sv
`timescale 1ns/1ps
module dee_nv_device #(
  parameter int PWRT_CYCLES = dee_pkg::PWRT_CYCLES,
  parameter int WRITE_CYCLES = dee_pkg::WRITE_CYCLES,
  parameter int NV_BYTES = dee_pkg::NV_BYTES
) (
  dee_if.dev bus,
  output logic done_flag,
  output logic write_busy
);

  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam int PW = $clog2(PWRT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(WRITE_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ERASE = CW'(WRITE_CYCLES / 2);
  localparam logic [PW-1:0] PWRT_LAST = PW'(PWRT_CYCLES - 1);

  if (WRITE_CYCLES < 2 || PWRT_CYCLES < 1 || NV_BYTES != (1 << dee_pkg::NV_AW))
  begin : g_chk
    $error("dee_nv_device: unsupported parameter values");
  end

  // ==========================================
  // Storage and state
  logic [7:0] mem [NV_BYTES];
  logic [7:0] addr_ff;
  logic [7:0] data_ff;
  logic pgd_ff;
  logic config_space_select_ff;
  logic row_ff;
  logic err_ff;
  logic write_permit_ff;
  logic wr_ff;
  logic rd_ff;
  logic flag_ff;
  logic tgt_ee_ff;
  logic busy_mark_ff;
  logic alive_ff;
  logic pwrt_done_ff;
  logic [PW-1:0] pwrt_cnt_ff;
  logic [CW-1:0] cnt_ff;
  logic [7:0] rdata_ff;
  logic busy_out_ff;
  dee_pkg::dee_key_t key_ff;
  dee_pkg::dee_key_t nxt_key;

  // ==========================================
  // Decode
  wire we_ctrl = bus.sfr_we && (bus.sfr_sel == dee_pkg::SFR_CTRL);
  wire we_key = bus.sfr_we && (bus.sfr_sel == dee_pkg::SFR_KEY);
  wire we_data = bus.sfr_we && (bus.sfr_sel == dee_pkg::SFR_DATA);
  wire we_addr = bus.sfr_we && (bus.sfr_sel == dee_pkg::SFR_ADDR);
  wire we_flag = bus.sfr_we && (bus.sfr_sel == dee_pkg::SFR_FLAG);
  wire ctrl_ok = we_ctrl && !wr_ff; // RULE_21
  wire [7:0] wd = bus.sfr_wdata;
  // Old permit value is used, so one write cannot both permit and start
  wire start_wr = ctrl_ok && wd[dee_pkg::CTL_WR] && write_permit_ff && (key_ff == dee_pkg::KEY_ARMED)
    && pwrt_done_ff; // RULE_06 RULE_17 RULE_21 RULE_22
  // Only the data EEPROM is readable this way
  wire start_rd = ctrl_ok && wd[dee_pkg::CTL_RD] && !wd[dee_pkg::CTL_PGD]
    && !wd[dee_pkg::CTL_CONFIG_SPACE_SELECT]; // RULE_11 RULE_04 RULE_05
  wire cnt_end = wr_ff && (cnt_ff == CNT_LAST);
  wire erase_pt = wr_ff && (cnt_ff == CNT_ERASE);
  // A reset that landed mid-write shows as busy mark without the live marker
  wire err_set = !alive_ff && busy_mark_ff; // RULE_08
  wire flag_clr = we_flag && !wd[dee_pkg::FLAG_DONE];
  wire [7:0] ctrl_rd = {pgd_ff, config_space_select_ff, 1'b0, row_ff, err_ff, write_permit_ff, wr_ff, rd_ff};
  wire [7:0] flag_rd = {3'h0, flag_ff, 4'h0};
  wire [7:0] rd_mux = (bus.sfr_sel == dee_pkg::SFR_CTRL) ? ctrl_rd :
                      (bus.sfr_sel == dee_pkg::SFR_DATA) ? data_ff :
                      (bus.sfr_sel == dee_pkg::SFR_ADDR) ? addr_ff :
                      (bus.sfr_sel == dee_pkg::SFR_FLAG) ? flag_rd :
                      8'h00; // RULE_03

  assign bus.sfr_rdata = rdata_ff;
  assign done_flag = flag_ff;
  assign write_busy = busy_out_ff;

  // ==========================================
  // Unlock sequence
  // Any other register write between the steps breaks the sequence
  always_comb
  begin
    nxt_key = dee_pkg::KEY_IDLE;
    if (!bus.sfr_we)
    begin
      nxt_key = key_ff;
    end
    else if (we_key && wd == dee_pkg::KEY_FIRST)
    begin
      nxt_key = dee_pkg::KEY_GOT_FIRST;
    end
    else if (we_key && wd == dee_pkg::KEY_SECOND && key_ff == dee_pkg::KEY_GOT_FIRST)
    begin
      nxt_key = dee_pkg::KEY_ARMED; // RULE_17
    end
  end

  always_ff @(posedge bus.pclk or negedge bus.presetn)
  begin
    if (!bus.presetn)
    begin
      key_ff <= dee_pkg::KEY_IDLE;
    end
    else
    begin
      key_ff <= nxt_key;
    end
  end

  // ==========================================
  // Power-up timer, kept across ordinary resets
  always_ff @(posedge bus.pclk or negedge bus.por_n)
  begin
    if (!bus.por_n)
    begin
      pwrt_cnt_ff <= '0;
      pwrt_done_ff <= 1'b0;
    end
    else if (!pwrt_done_ff)
    begin
      pwrt_cnt_ff <= pwrt_cnt_ff + PW'(1);
      pwrt_done_ff <= (pwrt_cnt_ff == PWRT_LAST); // RULE_22
    end
  end

  // ==========================================
  // Fields that survive an ordinary reset
  // Selects stay so firmware can tell which operation failed
  always_ff @(posedge bus.pclk or negedge bus.por_n)
  begin
    if (!bus.por_n)
    begin
      pgd_ff <= 1'b0;
      config_space_select_ff <= 1'b0;
      row_ff <= 1'b0;
      err_ff <= 1'b0;
      busy_mark_ff <= 1'b0;
    end
    else
    begin
      if (ctrl_ok)
      begin
        pgd_ff <= wd[dee_pkg::CTL_PGD]; // RULE_04
        config_space_select_ff <= wd[dee_pkg::CTL_CONFIG_SPACE_SELECT]; // RULE_05
        row_ff <= wd[dee_pkg::CTL_ROW]; // RULE_24
      end
      // Hardware set wins over a software clear in the same cycle
      err_ff <= err_set | (ctrl_ok ? wd[dee_pkg::CTL_ERR] : err_ff); // RULE_08
      busy_mark_ff <= start_wr | (busy_mark_ff & ~cnt_end & ~err_set);
    end
  end

  // ==========================================
  // Fields cleared by every reset
  always_ff @(posedge bus.pclk or negedge bus.presetn)
  begin
    if (!bus.presetn)
    begin
      alive_ff <= 1'b0;
      addr_ff <= dee_pkg::RST_BYTE; // RULE_09
      write_permit_ff <= 1'b0; // RULE_22
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      tgt_ee_ff <= 1'b0;
      cnt_ff <= '0;
      flag_ff <= 1'b0;
      rdata_ff <= 8'h00;
      busy_out_ff <= 1'b0;
    end
    else
    begin
      alive_ff <= 1'b1;
      if (we_addr && !wr_ff)
      begin
        addr_ff <= wd; // RULE_01 RULE_21
      end
      if (ctrl_ok)
      begin
        write_permit_ff <= wd[dee_pkg::CTL_WRITE_PERMIT]; // RULE_19 RULE_07
      end
      // Start bits only set by software; zero writes change nothing
      wr_ff <= start_wr | (wr_ff & ~cnt_end); // RULE_10 RULE_23
      rd_ff <= start_rd; // RULE_10 RULE_13
      if (start_wr)
      begin
        tgt_ee_ff <= !wd[dee_pkg::CTL_PGD] && !wd[dee_pkg::CTL_CONFIG_SPACE_SELECT];
      end
      cnt_ff <= (wr_ff && !cnt_end) ? cnt_ff + CW'(1) : '0; // RULE_02 RULE_23
      flag_ff <= cnt_end | (flag_ff & ~flag_clr); // RULE_12
      busy_out_ff <= start_wr | (wr_ff & ~cnt_end);
      if (bus.sfr_re)
      begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // ==========================================
  // Data register
  always_ff @(posedge bus.pclk or negedge bus.presetn)
  begin
    if (!bus.presetn)
    begin
      data_ff <= dee_pkg::RST_BYTE; // RULE_09
    end
    else if (start_rd)
    begin
      data_ff <= mem[addr_ff]; // RULE_13 RULE_14
    end
    else if (we_data && !wr_ff)
    begin
      data_ff <= wd; // RULE_14 RULE_21
    end
  end

  // ==========================================
  // Array: erase at mid-cycle, program at the end
  // Program memory and configuration targets are timed but not stored here
  always_ff @(posedge bus.pclk)
  begin
    if (erase_pt && tgt_ee_ff)
    begin
      mem[addr_ff] <= dee_pkg::BYTE_ERASED; // RULE_02
    end
    else if (cnt_end && tgt_ee_ff)
    begin
      mem[addr_ff] <= data_ff; // RULE_02 RULE_01
    end
  end

endmodule

// ===== rtl/dee_nv_host.sv
`timescale 1ns/1ps
module dee_nv_host (
  dee_if.host bus,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================
  // State
  dee_pkg::dee_host_state_t st_ff;
  logic op_wr_ff;
  logic [3:0] step_ff;
  logic [7:0] cmd_addr_ff;
  logic [7:0] cmd_data_ff;
  logic [7:0] rd_byte_ff;
  logic err_ff;
  logic busy_ff;
  logic we_ff;
  logic re_ff;
  logic [2:0] sel_ff;
  logic [7:0] wdata_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // ==========================================
  // APB decode
  wire setup = psel && !penable && !pready_ff;
  wire access = psel && penable && pready_ff;
  wire hit_cmd = (paddr == dee_pkg::APB_CMD);
  wire hit_sts = (paddr == dee_pkg::APB_STATUS);
  wire cmd_rd = pwdata[dee_pkg::CMD_READ];
  wire cmd_wr = pwdata[dee_pkg::CMD_WRITE];
  // A command arriving while busy, or asking both, is dropped
  wire cmd_go = access && pwrite && hit_cmd && !busy_ff && (cmd_rd ^ cmd_wr);
  wire [31:0] sts_word = {22'h0, err_ff, busy_ff, rd_byte_ff};

  // ==========================================
  // Step table
  // Write keeps the permit set from before the unlock until the poll sees the write finish
  logic step_rd;
  logic [2:0] step_sel;
  logic [7:0] step_data;
  always_comb
  begin
    step_rd = 1'b0;
    step_sel = dee_pkg::SFR_ADDR;
    step_data = cmd_addr_ff;
    if (op_wr_ff)
    begin
      unique case (step_ff)
        4'h0: step_data = cmd_addr_ff; // RULE_16
        4'h1:
        begin
          step_sel = dee_pkg::SFR_DATA;
          step_data = cmd_data_ff; // RULE_16
        end
        4'h2:
        begin
          step_sel = dee_pkg::SFR_CTRL;
          step_data = 8'h04; // RULE_20
        end
        4'h3:
        begin
          step_sel = dee_pkg::SFR_KEY;
          step_data = dee_pkg::KEY_FIRST; // RULE_17 RULE_18
        end
        4'h4:
        begin
          step_sel = dee_pkg::SFR_KEY;
          step_data = dee_pkg::KEY_SECOND; // RULE_17
        end
        4'h5:
        begin
          step_sel = dee_pkg::SFR_CTRL;
          step_data = 8'h06; // RULE_17
        end
        4'h6:
        begin
          step_sel = dee_pkg::SFR_CTRL;
          step_rd = 1'b1;
        end
        4'h7:
        begin
          step_sel = dee_pkg::SFR_CTRL;
          step_data = 8'h00; // RULE_20
        end
        default:
        begin
          step_sel = dee_pkg::SFR_FLAG;
          step_data = 8'h00;
        end
      endcase
    end
    else
    begin
      unique case (step_ff)
        4'h0: step_data = cmd_addr_ff; // RULE_15
        4'h1:
        begin
          step_sel = dee_pkg::SFR_CTRL;
          step_data = 8'h01; // RULE_15
        end
        default:
        begin
          step_sel = dee_pkg::SFR_DATA;
          step_rd = 1'b1;
        end
      endcase
    end
  end

  wire last_step = op_wr_ff ? (step_ff == 4'(dee_pkg::WR_STEPS - 1)) : (step_ff == 4'(dee_pkg::RD_STEPS - 1));
  wire poll_again = op_wr_ff && (step_ff == dee_pkg::POLL_STEP) && bus.sfr_rdata[dee_pkg::CTL_WR];

  assign bus.sfr_we = we_ff;
  assign bus.sfr_re = re_ff;
  assign bus.sfr_sel = sel_ff;
  assign bus.sfr_wdata = wdata_ff;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // ==========================================
  // APB slave, zero wait states
  always_ff @(posedge bus.pclk or negedge bus.presetn)
  begin
    if (!bus.presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end
    else
    begin
      pready_ff <= setup;
      pslverr_ff <= setup && !hit_cmd && !hit_sts;
      prdata_ff <= (setup && hit_sts) ? sts_word : 32'h0;
    end
  end

  // ==========================================
  // Sequencer
  always_ff @(posedge bus.pclk or negedge bus.presetn)
  begin
    if (!bus.presetn)
    begin
      st_ff <= dee_pkg::HS_IDLE;
      op_wr_ff <= 1'b0;
      step_ff <= 4'h0;
      cmd_addr_ff <= 8'h00;
      cmd_data_ff <= 8'h00;
      rd_byte_ff <= 8'h00;
      err_ff <= 1'b0;
      busy_ff <= 1'b0;
      we_ff <= 1'b0;
      re_ff <= 1'b0;
      sel_ff <= dee_pkg::SFR_CTRL;
      wdata_ff <= 8'h00;
    end
    else
    begin
      unique case (st_ff)
        dee_pkg::HS_IDLE:
        begin
          if (cmd_go)
          begin
            op_wr_ff <= cmd_wr;
            step_ff <= 4'h0;
            cmd_addr_ff <= pwdata[dee_pkg::CMD_ADDR_LSB +: 8];
            cmd_data_ff <= pwdata[dee_pkg::CMD_DATA_LSB +: 8];
            busy_ff <= 1'b1;
            st_ff <= dee_pkg::HS_ISSUE;
          end
        end
        dee_pkg::HS_ISSUE:
        begin
          we_ff <= !step_rd;
          re_ff <= step_rd;
          sel_ff <= step_sel;
          wdata_ff <= step_data;
          st_ff <= dee_pkg::HS_STROBE;
        end
        dee_pkg::HS_STROBE:
        begin
          we_ff <= 1'b0;
          re_ff <= 1'b0;
          st_ff <= step_rd ? dee_pkg::HS_READBACK : dee_pkg::HS_NEXT;
        end
        dee_pkg::HS_READBACK:
        begin
          if (op_wr_ff)
          begin
            err_ff <= bus.sfr_rdata[dee_pkg::CTL_ERR];
          end
          else
          begin
            rd_byte_ff <= bus.sfr_rdata;
          end
          st_ff <= poll_again ? dee_pkg::HS_ISSUE : dee_pkg::HS_NEXT;
        end
        dee_pkg::HS_NEXT:
        begin
          if (last_step)
          begin
            busy_ff <= 1'b0;
            st_ff <= dee_pkg::HS_IDLE;
          end
          else
          begin
            step_ff <= step_ff + 4'h1;
            st_ff <= dee_pkg::HS_ISSUE;
          end
        end
      endcase
    end
  end

endmodule

// ===== rtl/dee_pkg.sv
// Function
// RULE_01 - 256 bytes, byte access via address/data
// RULE_02 - Write erases then programs, internally timed
// RULE_03 - Unlock register has no storage, reads zero
// RULE_04 - Bit 7 selects program memory or EEPROM
// RULE_05 - Bit 6 selects configuration space
// RULE_06 - Write start blocked while write permit clear
// RULE_07 - Clearing permit never aborts running write
// RULE_08 - Reset during write sets error bit 3
// RULE_09 - Reset clears address and data registers
// RULE_10 - Start bits set by software, hardware clears
// RULE_11 - Read start ignored when program memory selected
// RULE_12 - Write completion sets sticky done flag
// RULE_13 - Read result ready for next instruction
// RULE_14 - Data register holds read value until changed
// RULE_15 - Firmware loads address, selects EEPROM, starts read
// RULE_16 - Firmware loads address and data before write
// RULE_17 - Write needs 55h, AAh, then start, exactly
// RULE_18 - Firmware keeps unlock sequence uninterrupted
// RULE_19 - Completion never clears write permit
// RULE_20 - Firmware keeps write permit clear when idle
// RULE_21 - Running write locks control, address, data
// RULE_22 - Power-up clears permit, timer inhibits writes
// RULE_23 - Write duration is a cycle count parameter
// RULE_24 - Error leaves memory and erase selects unchanged
package dee_pkg;

  // ==========================================
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int PWRT_TIME_MS = 72;
  localparam int PWRT_CYCLES = PWRT_TIME_MS * (CLK_HZ / 1000);
  localparam int WRITE_CYCLES = 64;

  // ==========================================
  // Storage
  localparam int NV_BYTES = 256;
  localparam int NV_AW = 8;

  // ==========================================
  // Register port of the device
  localparam int SFR_AW = 3;
  localparam logic [2:0] SFR_CTRL = 3'h0;
  localparam logic [2:0] SFR_KEY = 3'h1;
  localparam logic [2:0] SFR_DATA = 3'h2;
  localparam logic [2:0] SFR_ADDR = 3'h3;
  localparam logic [2:0] SFR_FLAG = 3'h4;

  // Control and flag register fields
  localparam int CTL_PGD = 7;
  localparam int CTL_CONFIG_SPACE_SELECT = 6;
  localparam int CTL_ROW = 4;
  localparam int CTL_ERR = 3;
  localparam int CTL_WRITE_PERMIT = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;
  localparam int FLAG_DONE = 4;

  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} dee_key_t;

  // ==========================================
  // APB map of the controller
  localparam int APB_AW = 12;
  localparam logic [11:0] APB_CMD = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam int CMD_READ = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int STS_BUSY = 8;
  localparam int STS_ERR = 9;

  localparam int WR_STEPS = 9;
  localparam int RD_STEPS = 3;
  localparam logic [3:0] POLL_STEP = 4'h6;

  typedef enum {HS_IDLE, HS_ISSUE, HS_STROBE, HS_READBACK, HS_NEXT} dee_host_state_t;

endpackage

// ===== sim/data_eeprom_access_controller_tb.sv
`timescale 1ns/1ps
module data_eeprom_access_controller_tb;
  // Short counts keep the run small
  localparam int PWRT = 60;
  localparam int WCYC = 8;
  logic pclk;
  logic presetn;
  logic por_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic done_flag;
  logic write_busy;
  logic [31:0] st;
  logic err;
  logic [7:0] addrs [3] = '{8'h00, 8'hFF, 8'h7E};
  logic [7:0] vals [3] = '{8'hA5, 8'h3C, 8'h01};
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  dee_if dee_if_inst (.pclk(pclk), .presetn(presetn), .por_n(por_n));
  dee_nv_device #(.PWRT_CYCLES(PWRT), .WRITE_CYCLES(WCYC), .NV_BYTES(dee_pkg::NV_BYTES)) dee_nv_device_inst (
    .bus(dee_if_inst.dev), .done_flag(done_flag), .write_busy(write_busy));
  dee_nv_host dee_nv_host_inst (.bus(dee_if_inst.host), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dee_monitor #(.WRITE_CYCLES(WCYC), .PWRT_CYCLES(PWRT)) dee_monitor_inst (.pclk(pclk), .presetn(presetn),
    .por_n(por_n), .sfr_we(dee_if_inst.sfr_we), .sfr_re(dee_if_inst.sfr_re), .sfr_sel(dee_if_inst.sfr_sel),
    .sfr_wdata(dee_if_inst.sfr_wdata), .sfr_rdata(dee_if_inst.sfr_rdata), .done_flag(done_flag),
    .write_busy(write_busy));

  // ==========================================
  // Clock and timeout
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================
  // Tasks
  task automatic wrap_up();
    $display("checks=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask

  // Request holds until pready is sampled high; the answer is taken at that same edge
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_cmd(input logic [31:0] cmd);
    apb_xfer(1'b1, dee_pkg::APB_CMD, cmd, st, err);
    do
    begin
      apb_xfer(1'b0, dee_pkg::APB_STATUS, 32'h0, st, err);
    end
    while (st[dee_pkg::STS_BUSY] !== 1'b0);
  endtask

  task automatic nv_write(input logic [7:0] a, input logic [7:0] d);
    do_cmd({8'h00, d, a, 8'h02});
  endtask

  task automatic nv_read(input logic [7:0] a, input logic [7:0] exp);
    do_cmd({16'h0000, a, 8'h01});
    check_byte(st[7:0], exp);
  endtask

  task automatic do_reset(input logic pwr);
    @(posedge pclk);
    presetn <= 1'b0;
    por_n <= ~pwr;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
  endtask

  // ==========================================
  // Tests
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    por_n = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    repeat (PWRT) @(posedge pclk);
    foreach (addrs[i])
      nv_write(addrs[i], vals[i]);
    check_bit(st[dee_pkg::STS_ERR], 1'b0);
    foreach (addrs[i])
      nv_read(addrs[i], vals[i]);
    $display("test boundary write and read done");
    apb_xfer(1'b0, 12'h008, 32'h0, st, err);
    check_bit(err, 1'b1);
    apb_xfer(1'b1, 12'hFFC, 32'h0000_00FF, st, err);
    check_bit(err, 1'b1);
    $display("test unmapped access done");
    // Neither or both command bits: no access at all
    do_cmd({8'h00, 8'h99, 8'h00, 8'h03});
    do_cmd({8'h00, 8'h66, 8'h00, 8'h00});
    nv_read(8'h00, 8'hA5);
    $display("test malformed command done");
    // Reset lands inside a timed write: error shows, address and data clear
    apb_xfer(1'b1, dee_pkg::APB_CMD, {8'h00, 8'hC3, 8'h7E, 8'h02}, st, err);
    while (write_busy !== 1'b1)
      @(posedge pclk);
    do_reset(1'b0);
    @(posedge pclk);
    check_bit(dee_nv_device_inst.err_ff, 1'b1);
    check_byte(dee_nv_device_inst.addr_ff, 8'h00);
    check_byte(dee_nv_device_inst.data_ff, 8'h00);
    nv_write(8'h7E, 8'hC3);
    nv_read(8'h7E, 8'hC3);
    $display("test interrupted write done");
    // Write issued at once after power-on must be refused
    do_reset(1'b1);
    nv_write(8'hFF, 8'h5A);
    nv_read(8'hFF, 8'h3C);
    repeat (PWRT) @(posedge pclk);
    nv_write(8'hFF, 8'h5A);
    nv_read(8'hFF, 8'h5A);
    $display("test power-up inhibit done");
    wrap_up();
  end
endmodule

// ===== sim/dee_monitor.sv
`timescale 1ns/1ps
// ==========================================
// Register port checker
module dee_monitor #(
  parameter int WRITE_CYCLES = dee_pkg::WRITE_CYCLES,
  parameter int PWRT_CYCLES = dee_pkg::PWRT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic sfr_we,
  input wire logic sfr_re,
  input wire logic [2:0] sfr_sel,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic done_flag,
  input wire logic write_busy
);
  logic [10:0] hist0_ff;
  logic [10:0] hist1_ff;
  logic [10:0] hist2_ff;
  logic [7:0] busy_cnt_ff;
  logic [31:0] pwr_cnt_ff;
  wire logic flag_clr = sfr_we && sfr_sel == dee_pkg::SFR_FLAG && !sfr_wdata[dee_pkg::FLAG_DONE];
  wire logic ctl_rd = sfr_re && sfr_sel == dee_pkg::SFR_CTRL;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Last three register writes, newest first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist0_ff <= '0;
      hist1_ff <= '0;
      hist2_ff <= '0;
    end
    else if (sfr_we)
    begin
      hist0_ff <= {sfr_sel, sfr_wdata};
      hist1_ff <= hist0_ff;
      hist2_ff <= hist1_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      busy_cnt_ff <= '0;
    else
      busy_cnt_ff <= write_busy ? busy_cnt_ff + 8'h01 : 8'h00;
  end

  // Power-up timer runs only from the power-on reset
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      pwr_cnt_ff <= '0;
    else if (pwr_cnt_ff < PWRT_CYCLES)
      pwr_cnt_ff <= pwr_cnt_ff + 32'h1;
  end

  property p_busy_len;
    $fell(write_busy) |-> busy_cnt_ff == WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("timed write length wrong");

  property p_done_set;
    $fell(write_busy) |-> done_flag;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set at write end");

  property p_done_sticky;
    done_flag && !flag_clr |=> done_flag;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped by itself");

  property p_done_clear;
    done_flag && flag_clr && !write_busy |=> !done_flag;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag clear ignored");

  property p_permit_kept;
    ctl_rd && hist0_ff == {dee_pkg::SFR_CTRL, 8'h06} |=> sfr_rdata[dee_pkg::CTL_WRITE_PERMIT];
  endproperty
  a_permit_kept: assert property (p_permit_kept) else $error("write permit lost");

  property p_wr_bit;
    ctl_rd |=> sfr_rdata[dee_pkg::CTL_WR] == $past(write_busy);
  endproperty
  a_wr_bit: assert property (p_wr_bit) else $error("start bit differs from write state");

  property p_rdata_hold;
    !sfr_re |=> $stable(sfr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");

  property p_start_order;
    $rose(write_busy) |-> hist0_ff[10:8] == dee_pkg::SFR_CTRL && hist0_ff[dee_pkg::CTL_WR]
      && hist1_ff == {dee_pkg::SFR_KEY, dee_pkg::KEY_SECOND} && hist2_ff == {dee_pkg::SFR_KEY, dee_pkg::KEY_FIRST};
  endproperty
  a_start_order: assert property (p_start_order) else $error("write began without unlock order");

  property p_pwrt;
    $rose(write_busy) |-> pwr_cnt_ff >= PWRT_CYCLES;
  endproperty
  a_pwrt: assert property (p_pwrt) else $error("write began during power-up time");

  c_write: cover property ($rose(write_busy));
  c_flag_clr: cover property (done_flag && flag_clr);
  c_data_rd: cover property (sfr_re && sfr_sel == dee_pkg::SFR_DATA);
endmodule
